// File: src/osa_map.svh
// Register offsets, field positions, reset values and advance counts of the output advancement bank.
// Assumes inclusion by its bare name from the package; the modules use its macros without including it.
`ifndef OSA_MAP_SVH
`define OSA_MAP_SVH

// Printed offsets are register indices; byte address is four times the index
`define OSA_LOCAL_BASE_IDX 8'h83
`define OSA_LOCAL_LAST_IDX 8'hA2
`define OSA_BACK_BASE_IDX 8'hA3
`define OSA_BACK_LAST_IDX 8'hC2
`define OSA_MODE_IDX 8'hF0
`define OSA_ADV_LSB 0
`define OSA_ADV_MSB 1
`define OSA_ADV_RESET 2'h0
`define OSA_STREAMS 32
`define OSA_STREAMS_32M 16
// Advance per field step, in system clock cycles
`define OSA_STEP_LOW 2
`define OSA_STEP_32M 1
`define OSA_MAX_ADV 6

`endif

// File: src/osa_pkg.sv
// Types shared by the output advancement bank.
// Assumes osa_map.svh is on the include path.
package osa_pkg;
  `include "osa_map.svh"

  typedef logic [1:0] osa_adv_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } osa_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } osa_apb_rsp_t;

  typedef enum logic [1:0] {
    OSA_IDLE = 2'b00,
    OSA_ACCESS = 2'b01
  } osa_state_t;
endpackage

// File: src/osa_shift.sv
// Per-stream advance line: picks one of seven taps of a delay line.
// Assumes input stream is delayed by the maximum advance; zero advance uses the longest tap.
`timescale 1ns/1ps
module osa_shift
  import osa_pkg::*;
#(
  parameter int MAX_ADV = `OSA_MAX_ADV
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Stream
  input wire logic din,
  input wire logic [2:0] adv_cycles,
  output logic dout
);
  typedef struct packed {
    logic [MAX_ADV:0] line;
    logic out;
  } osa_shift_st_t;

  osa_shift_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.line = {s_q.line[MAX_ADV-1:0], din};
      // Longest tap is the frame-aligned position
      s_d.out = s_q.line[3'(MAX_ADV) - adv_cycles];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.out;
endmodule

// File: src/osa_bank.sv
// Output advancement bank: APB registers and per-stream output shift for local and backplane ports.
// Assumes serial data arrive at the system clock rate, already timed for the maximum advance.
//
// Notes on behaviour
// - Thirty-two local advance registers at indices 83h to A2h set each local stream's advance.
// - Thirty-two backplane advance registers at indices A3h to C2h set each backplane stream's advance.
// - In low-rate mode registers 0 to 31 apply, in 32 Mbps mode only registers 0 to 15.
// - Each register holds a two-bit field in bits 1:0 resetting to zero; upper bits read zero.
// - At 2 to 16 Mbps the field advances the output by 0, 2, 4 or 6 cycles.
// - At 32 Mbps the field advances the output by 0, 1, 2 or 3 cycles.
// - The advance is per stream, relative to that stream's frame boundary.
// - A zero field keeps the stream aligned with the generated frame pulse.
`timescale 1ns/1ps
module osa_bank
  import osa_pkg::*;
#(
  parameter int STREAMS = `OSA_STREAMS
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame timing
  input wire logic frame_pulse_in,
  output logic generated_frame_pulse,
  // Local streams
  input wire logic [STREAMS-1:0] local_stream_in,
  output logic [STREAMS-1:0] local_serial_out,
  // Backplane streams
  input wire logic [STREAMS-1:0] backplane_stream_in,
  output logic [STREAMS-1:0] backplane_serial_out
);
  typedef struct packed {
    logic [STREAMS-1:0][1:0] local_adv;
    logic [STREAMS-1:0][1:0] back_adv;
    logic local_32m;
    logic back_32m;
    logic [31:0] rdata;
    logic err;
    logic [`OSA_MAX_ADV:0] fp_line;
    logic fp;
  } osa_st_t;

  osa_st_t s_q, s_d;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic [7:0] idx;
  logic aligned;
  logic in_local;
  logic in_back;
  logic is_mode;
  logic [7:0] loc_n;
  logic [7:0] bak_n;
  logic access;

  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0);
  assign in_local = aligned && idx >= `OSA_LOCAL_BASE_IDX && idx <= `OSA_LOCAL_LAST_IDX;
  assign in_back = aligned && idx >= `OSA_BACK_BASE_IDX && idx <= `OSA_BACK_LAST_IDX;
  assign is_mode = aligned && idx == `OSA_MODE_IDX;
  assign loc_n = idx - 8'(`OSA_LOCAL_BASE_IDX);
  assign bak_n = idx - 8'(`OSA_BACK_BASE_IDX);
  assign access = psel && penable && ce;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (access) begin
      s_d.err = !(in_local || in_back || is_mode);
      s_d.rdata = 32'h0;
      if (pwrite) begin
        if (in_local) begin
          s_d.local_adv[loc_n[4:0]] = pwdata[`OSA_ADV_MSB:`OSA_ADV_LSB];
        end
        if (in_back) begin
          s_d.back_adv[bak_n[4:0]] = pwdata[`OSA_ADV_MSB:`OSA_ADV_LSB];
        end
        if (is_mode) begin
          s_d.local_32m = pwdata[0];
          s_d.back_32m = pwdata[1];
        end
      end
    end
    if (ce) begin
      // frame pulse on the zero-advance tap
      s_d.fp_line = {s_q.fp_line[`OSA_MAX_ADV-1:0], frame_pulse_in};
      s_d.fp = s_q.fp_line[`OSA_MAX_ADV];
    end
  end

  // Read data is combinational from the registers; the bus answers with no wait state while ce is high
  always_comb begin
    prdata = 32'h0;
    if (psel && penable && !pwrite) begin
      if (in_local) begin
        prdata = {30'h0, s_q.local_adv[loc_n[4:0]]};
      end else if (in_back) begin
        prdata = {30'h0, s_q.back_adv[bak_n[4:0]]};
      end else if (is_mode) begin
        prdata = {30'h0, s_q.back_32m, s_q.local_32m};
      end
    end
  end

  // Freezing on low enable also stretches the access phase
  assign pready = ce;
  assign pslverr = psel && penable && !(in_local || in_back || is_mode);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign generated_frame_pulse = s_q.fp;

  // ------------------------------------------------------------
  // Per-stream advance
  // ------------------------------------------------------------
  // encoding picked from port rate mode
  function automatic logic [2:0] adv_count(input logic [1:0] field, input logic is_32m, input int n);
    logic [2:0] c;
    c = 3'h0;
    // upper half unused in 32 Mbps mode
    if (is_32m && n >= `OSA_STREAMS_32M) begin
      c = 3'h0;
    end else if (is_32m) begin
      c = 3'(field * `OSA_STEP_32M);
    end else begin
      c = 3'(field * `OSA_STEP_LOW);
    end
    return c;
  endfunction

  genvar g;
  generate
    for (g = 0; g < STREAMS; g++) begin : g_str
      osa_shift #(.MAX_ADV(`OSA_MAX_ADV)) u_loc (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .din(local_stream_in[g]),
        .adv_cycles(adv_count(s_q.local_adv[g], s_q.local_32m, g)),
        .dout(local_serial_out[g])
      );
      osa_shift #(.MAX_ADV(`OSA_MAX_ADV)) u_bak (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .din(backplane_stream_in[g]),
        .adv_cycles(adv_count(s_q.back_adv[g], s_q.back_32m, g)),
        .dout(backplane_serial_out[g])
      );
    end
  endgenerate
endmodule

// File: tb/osa_props.sv
// Port checker for the output advancement bank.
// Assumes a bind onto osa_bank; follows the stream 0 fields through APB writes.
`timescale 1ns/1ps
module osa_props #(
  parameter int STREAMS = 32
) (
  // APB
  input wire logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr,
  input wire logic [31:0] paddr, pwdata, prdata,
  // Streams
  input wire logic frame_pulse_in, generated_frame_pulse,
  input wire logic [STREAMS-1:0] local_stream_in, local_serial_out, backplane_stream_in, backplane_serial_out
);
  logic [7:0] hf_q, hl_q, hb_q;
  logic [3:0] qt_q;
  logic [1:0] fl_q, fb_q, md_q;
  logic acc, wr;
  logic [2:0] al, ab;
  assign acc = psel && penable;
  assign wr = acc && pwrite && ce;
  assign al = md_q[0] ? {1'h0, fl_q} : {fl_q, 1'h0};
  assign ab = md_q[1] ? {1'h0, fb_q} : {fb_q, 1'h0};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {hf_q, hl_q, hb_q, qt_q, fl_q, fb_q, md_q} <= '0;
    end else begin
      hf_q <= {hf_q[6:0], frame_pulse_in};
      hl_q <= {hl_q[6:0], local_stream_in[0]};
      hb_q <= {hb_q[6:0], backplane_stream_in[0]};
      // Delay line refills after a write or stall
      qt_q <= (wr || !ce) ? 4'h0 : qt_q + 4'(qt_q != 4'hF);
      if (wr && paddr == 32'h20C) fl_q <= pwdata[1:0];
      if (wr && paddr == 32'h28C) fb_q <= pwdata[1:0];
      if (wr && paddr == 32'h3C0) md_q <= pwdata[1:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_is_ce: assert property (pready == ce) else $error("pready wrong");
  a_bad_refused: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0) else $error("no refusal");
  a_bank_mapped: assert property (acc && paddr[1:0] == 2'h0 && paddr inside {[32'h20C:32'h308]} |-> !pslverr)
    else $error("bank refused");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:2] == 30'h0) else $error("upper bits");
  a_field_back: assert property (acc && !pwrite && paddr == 32'h20C |-> prdata[1:0] == fl_q) else $error("field");
  a_pulse_align: assert property (qt_q[3] |-> generated_frame_pulse == hf_q[7]) else $error("pulse");
  a_local_lead: assert property (qt_q[3] |-> local_serial_out[0] == hl_q[3'h7 - al]) else $error("local");
  a_back_lead: assert property (qt_q[3] |-> backplane_serial_out[0] == hb_q[3'h7 - ab]) else $error("back");
  c_write: cover property (wr);
  c_refuse: cover property (acc && pslverr);
  c_lead: cover property (qt_q[3] && al != 3'h0 && local_serial_out[0]);
endmodule
bind osa_bank osa_props #(.STREAMS(STREAMS)) i_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .frame_pulse_in(frame_pulse_in), .generated_frame_pulse(generated_frame_pulse),
  .local_stream_in(local_stream_in), .local_serial_out(local_serial_out),
  .backplane_stream_in(backplane_stream_in), .backplane_serial_out(backplane_serial_out));

// File: tb/osa_rx.sv
// Stream receiver model: logs the cycle of the last high bit on each output.
// Assumes one marker bit per measurement round.
`timescale 1ns/1ps
module osa_rx (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Receive side
  input wire logic frame_pulse,
  input wire logic [63:0] rx,
  output int frame_at,
  output int rx_at [64]
);
  int now;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      now <= 0;
      frame_at <= 0;
      for (int i = 0; i < 64; i++) rx_at[i] <= 0;
    end else begin
      now <= now + 1;
      if (frame_pulse) frame_at <= now;
      for (int i = 0; i < 64; i++) if (rx[i]) rx_at[i] <= now;
    end
  end
endmodule

// File: tb/osa_bank_test.sv
// Bench for osa_bank: APB register tests and stream lead measurement.
// Assumes ce stays high; lead is frame pulse time minus data time.
`timescale 1ns/1ps
module osa_bank_test;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, fp = 0, pready, pslverr, gfp, e;
  logic [31:0] paddr = '0, pwdata = '0, prdata, r, lin = '0, bin = '0, lout, bout;
  int bad_count = 0, check_count = 0, frame_at, rx_at [64], x;
  osa_bank i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_pulse_in(fp),
    .generated_frame_pulse(gfp), .local_stream_in(lin), .local_serial_out(lout), .backplane_stream_in(bin),
    .backplane_serial_out(bout));
  osa_rx i_rx (.pclk(pclk), .presetn(presetn), .frame_pulse(gfp), .rx({bout, lout}), .frame_at(frame_at),
    .rx_at(rx_at));
  initial forever #50 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    // A wait that runs out counts as a mismatch
    if (pready !== 1'h1) bad_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic fire();
    repeat (9) @(posedge pclk);
    fp <= 1'h1;
    lin <= '1;
    bin <= '1;
    @(posedge pclk);
    fp <= 1'h0;
    lin <= '0;
    bin <= '0;
    repeat (12) @(posedge pclk);
  endtask
  task automatic stop_test();
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 64; i++) begin
      apb(32'h20C + 32'(4 * i), 1'h0, '0);
      chk(r, 32'h0);
      apb(32'h20C + 32'(4 * i), 1'h1, 32'((i + 1) % 4));
    end
    for (int i = 0; i < 64; i++) begin
      apb(32'h20C + 32'(4 * i), 1'h0, '0);
      chk(r, 32'((i + 1) % 4));
    end
    apb(32'h20E, 1'h1, 32'h3);
    chk(32'(e), 32'h1);
    apb(32'h20C, 1'h0, '0);
    chk(r, 32'h1);
    for (int m = 0; m < 4; m++) begin
      apb(32'h3C0, 1'h1, 32'(m));
      fire();
      for (int i = 0; i < 64; i++) begin
        x = (m >> (i / 32)) % 2 ? ((i % 32) < 16 ? (i + 1) % 4 : 0) : 2 * ((i + 1) % 4);
        chk(32'(frame_at - rx_at[i]), 32'(x));
      end
    end
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    stop_test();
  end
endmodule
